// file: src/nbs_setup.sv
// BAR pair setup, base masking and upper translated base register
`timescale 1ns/1ps
`include "nbs_map.svh"
// Contract
// - Six-bit size, reset 1, space is two to size bytes, zero leaves every base bit writable in 64-bit mode.
// - Base field bit zero stands for address bit four.
// - Size zero makes every base bit writable in 64-bit mode, only the low 28 otherwise.
// - Nonzero size: bits at or above size writable, lower ones read zero.
// - Nonzero size below four makes whole base field read-only zero.
// - I/O or 32-bit memory clips size above 32; only type enables 64-bit.
// - Enable bit 31, reset zero; clear makes BAR disabled, reading zero.
// - Enable survives hot resets; fundamental reset clears it.
// - 64-bit memory mode uses upper translated base as high 32 bits.
// - 64-bit memory mode makes all 32 upper translated bits read-write.
// - Space select zero is memory, one is I/O.
// - 64-bit memory mode makes upper setup register read-only zero.
module nbs_setup
    import nbs_pkg::*;
(
    // Clock and resets
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic hot_reset,
    // Register port
    input wire nbs_pkg::nbs_addr_t reg_addr,
    input wire nbs_pkg::nbs_word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output nbs_pkg::nbs_word_t reg_rdata,
    // Decode outputs
    output logic bar_enabled,
    output logic bar_is_io,
    output logic bar_wide,
    output logic [63:0] bar_base_addr,
    output logic [63:0] translated_base_addr
);
    import nbs_pkg::*;

    // Low setup register fields
    logic low_space;
    logic [1:0] low_type;
    logic low_pref;
    logic [5:0] low_size;
    logic low_en;
    // High setup register fields
    logic high_space;
    logic [1:0] high_type;
    logic high_pref;
    logic [5:0] high_size;
    logic high_en;
    // Base and translated base storage
    logic [59:0] base_field;
    logic [27:0] tbase_low;
    logic [31:0] tbase_high;

    nbs_rst_kind_t rst_kind;
    logic [59:0] mask;
    logic wide_mode;
    logic [59:0] base_visible;
    logic [59:0] next_base;
    logic [59:0] wr_sel;
    logic [59:0] wr_val;
    logic hit_setup_low, hit_setup_high, hit_tbase_high, hit_base_low, hit_base_high, hit_status;
    nbs_word_t setup_low_word, setup_high_word, tbase_high_word, base_low_word, base_high_word;
    nbs_word_t status_word, next_rdata;

    function automatic nbs_word_t pack_setup(input logic en, input logic [5:0] size, input logic pref,
                                             input logic [1:0] typ, input logic space);
        pack_setup = '0;
        pack_setup[`NBS_EN_BIT] = en;
        pack_setup[`NBS_SIZE_MSB:`NBS_SIZE_LSB] = size;
        pack_setup[`NBS_PREF_BIT] = pref;
        pack_setup[`NBS_TYPE_MSB:`NBS_TYPE_LSB] = typ;
        pack_setup[`NBS_SPACE_BIT] = space;
    endfunction

    // Reset kind: hot keeps the sticky state, fundamental clears it
    assign rst_kind = reset ? NBS_RST_FULL : (hot_reset ? NBS_RST_HOT : NBS_RST_NONE);

    assign wide_mode = (low_space == `NBS_SPACE_MEM) && (low_type == `NBS_TYPE_ADDR64);

    nbs_base_mask u_mask (
        .size(low_size),
        .wide_decode(wide_mode),
        .mask(mask)
    );

    assign base_visible = base_field & mask;

    assign hit_setup_low = (reg_addr == `NBS_OFF_SETUP_LOW);
    assign hit_setup_high = (reg_addr == `NBS_OFF_SETUP_HIGH);
    assign hit_tbase_high = (reg_addr == `NBS_OFF_TBASE_HIGH);
    assign hit_base_low = (reg_addr == `NBS_OFF_BASE_LOW);
    assign hit_base_high = (reg_addr == `NBS_OFF_BASE_HIGH);
    assign hit_status = (reg_addr == `NBS_OFF_STATUS);

    // Each half takes only its own writable bits; the other half is left alone
    assign wr_sel = (reg_wr && hit_base_low) ? {32'h0, 28'hfff_ffff} :
                    (reg_wr && hit_base_high && wide_mode) ? {32'hffff_ffff, 28'h0} : 60'h0;
    assign wr_val = hit_base_high ? {reg_wdata, 28'h0} : {32'h0, reg_wdata[31:4]};
    assign next_base = (base_field & ~(wr_sel & mask)) | (wr_val & wr_sel & mask);

    assign setup_low_word = pack_setup(low_en, low_size, low_pref, low_type, low_space);
    assign setup_high_word = wide_mode ? 32'h0 :
        pack_setup(high_en, high_size, high_pref, high_type, high_space);
    assign tbase_high_word = wide_mode ? tbase_high : {tbase_high[31:4], 4'h0};
    assign base_low_word = low_en ? {base_visible[27:0], 3'h0, low_space} : 32'h0;
    assign base_high_word = (low_en && wide_mode) ? base_visible[59:28] : 32'h0;
    assign status_word = {29'h0, wide_mode, low_space, low_en};

    assign next_rdata = hit_setup_low ? setup_low_word :
                        hit_setup_high ? setup_high_word :
                        hit_tbase_high ? tbase_high_word :
                        hit_base_low ? base_low_word :
                        hit_base_high ? base_high_word :
                        hit_status ? status_word : 32'h0;

    // Low setup: size reset always, sticky fields only on power-up
    always_ff @(posedge ref_clk) begin
        if (rst_kind != NBS_RST_NONE) begin
            low_size <= `NBS_SIZE_RST;
        end else if (reg_wr && hit_setup_low) begin
            low_size <= reg_wdata[`NBS_SIZE_MSB:`NBS_SIZE_LSB];
        end
    end

    // Enable, space, type, pref survive hot resets; only basic init clears them
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            low_en <= 1'b0;
            low_space <= `NBS_SPACE_MEM;
            low_type <= `NBS_TYPE_ADDR32;
            low_pref <= 1'b0;
        end else if (reg_wr && hit_setup_low && rst_kind == NBS_RST_NONE) begin
            low_en <= reg_wdata[`NBS_EN_BIT];
            low_space <= reg_wdata[`NBS_SPACE_BIT];
            low_type <= reg_wdata[`NBS_SPACE_BIT] ? `NBS_TYPE_ADDR32 : reg_wdata[`NBS_TYPE_MSB:`NBS_TYPE_LSB];
            low_pref <= reg_wdata[`NBS_PREF_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst_kind != NBS_RST_NONE) begin
            high_size <= `NBS_SIZE_RST;
        end else if (reg_wr && hit_setup_high && !wide_mode) begin
            high_size <= reg_wdata[`NBS_SIZE_MSB:`NBS_SIZE_LSB];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            high_en <= 1'b0;
            high_space <= `NBS_SPACE_MEM;
            high_type <= `NBS_TYPE_ADDR32;
            high_pref <= 1'b0;
        end else if (reg_wr && hit_setup_high && !wide_mode && rst_kind == NBS_RST_NONE) begin
            high_en <= reg_wdata[`NBS_EN_BIT];
            high_space <= reg_wdata[`NBS_SPACE_BIT];
            high_type <= reg_wdata[`NBS_SPACE_BIT] ? `NBS_TYPE_ADDR32 : reg_wdata[`NBS_TYPE_MSB:`NBS_TYPE_LSB];
            high_pref <= reg_wdata[`NBS_PREF_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tbase_high <= 32'h0;
        end else if (reg_wr && hit_tbase_high && rst_kind == NBS_RST_NONE) begin
            tbase_high[31:4] <= reg_wdata[31:4];
            // Low nibble is reserved outside 64-bit mode
            if (wide_mode) begin
                tbase_high[3:0] <= reg_wdata[3:0];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst_kind != NBS_RST_NONE) begin
            base_field <= '0;
        end else begin
            base_field <= next_base;
        end
    end

    // Read data stands one cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 32'h0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            bar_enabled <= 1'b0;
            bar_is_io <= 1'b0;
            bar_wide <= 1'b0;
            bar_base_addr <= 64'h0;
            translated_base_addr <= 64'h0;
        end else begin
            bar_enabled <= low_en && (low_size == 6'h00 || low_size >= 6'h04);
            bar_is_io <= low_space;
            bar_wide <= wide_mode;
            bar_base_addr <= {base_visible, 4'h0};
            translated_base_addr <= wide_mode ? {tbase_high, tbase_low, 4'h0} : {32'h0, tbase_low, 4'h0};
        end
    end

    // Low translated base lives in the neighbouring register; zero here
    assign tbase_low = 28'h0;

    property p_size_reset;
        @(posedge ref_clk) reset |=> (low_size == `NBS_SIZE_RST);
    endproperty
    a_size_reset: assert property (p_size_reset) else $error("size not one after reset");

    property p_high_zero_wide;
        @(posedge ref_clk) disable iff (reset) (reg_rd && hit_setup_high && wide_mode) |=> (reg_rdata == 32'h0);
    endproperty
    a_high_zero_wide: assert property (p_high_zero_wide) else $error("upper setup not zero in wide mode");

    property p_disabled_reads_zero;
        @(posedge ref_clk) disable iff (reset) (reg_rd && hit_base_low && !low_en) |=> (reg_rdata == 32'h0);
    endproperty
    a_disabled_reads_zero: assert property (p_disabled_reads_zero) else $error("disabled bar read nonzero");

    property p_small_size_zero;
        @(posedge ref_clk) disable iff (reset) (low_size != 6'h00 && low_size < 6'h04) |-> (mask == '0);
    endproperty
    a_small_size_zero: assert property (p_small_size_zero) else $error("small size left base writable");

    property p_size_zero_all;
        @(posedge ref_clk) disable iff (reset) (low_size == 6'h00 && wide_mode) |-> (&mask);
    endproperty
    a_size_zero_all: assert property (p_size_zero_all) else $error("size zero not fully writable");

    property p_narrow_clip;
        @(posedge ref_clk) disable iff (reset) !wide_mode |-> (mask[59:28] == '0);
    endproperty
    a_narrow_clip: assert property (p_narrow_clip) else $error("narrow mode writes above bit 32");

    property p_en_sticky;
        @(posedge ref_clk) hot_reset && !reset |=> $stable(low_en);
    endproperty
    a_en_sticky: assert property (p_en_sticky) else $error("enable lost on hot reset");

    property p_tbase_full;
        @(posedge ref_clk) disable iff (reset) (reg_rd && hit_tbase_high && wide_mode) |=> (reg_rdata == $past(tbase_high));
    endproperty
    a_tbase_full: assert property (p_tbase_full) else $error("upper translated base not full width");

    // Register events watched by the checks below
    sequence s_setup_low_rd;
        reg_rd && hit_setup_low;
    endsequence

    sequence s_setup_high_wr_wide;
        reg_wr && hit_setup_high && wide_mode && !hot_reset;
    endsequence

    sequence s_tbase_wr_wide;
        reg_wr && hit_tbase_high && wide_mode && !hot_reset;
    endsequence

    sequence s_base_low_wr;
        reg_wr && hit_base_low && !hot_reset;
    endsequence

    sequence s_base_high_wr_narrow;
        reg_wr && hit_base_high && !wide_mode && !hot_reset;
    endsequence

    property p_reserved_zero;
        @(posedge ref_clk) disable iff (reset) s_setup_low_rd |=> (reg_rdata[30:10] == 21'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved setup bits not zero");

    property p_io_type_zero;
        @(posedge ref_clk) disable iff (reset) (low_space == `NBS_SPACE_IO) |-> (low_type == `NBS_TYPE_ADDR32);
    endproperty
    a_io_type_zero: assert property (p_io_type_zero) else $error("io space with nonzero type");

    property p_high_setup_locked;
        @(posedge ref_clk) disable iff (reset) s_setup_high_wr_wide |=> ($stable(high_size) && $stable(high_en));
    endproperty
    a_high_setup_locked: assert property (p_high_setup_locked) else $error("upper setup written in wide mode");

    property p_tbase_write;
        @(posedge ref_clk) disable iff (reset) s_tbase_wr_wide |=> (tbase_high == $past(reg_wdata));
    endproperty
    a_tbase_write: assert property (p_tbase_write) else $error("wide upper base write lost bits");

    property p_base_halves;
        @(posedge ref_clk) disable iff (reset) s_base_low_wr |=> (base_field[59:28] == $past(base_field[59:28]));
    endproperty
    a_base_halves: assert property (p_base_halves) else $error("low base write changed high half");

    property p_narrow_high_ignored;
        @(posedge ref_clk) disable iff (reset) s_base_high_wr_narrow |=> $stable(base_field);
    endproperty
    a_narrow_high_ignored: assert property (p_narrow_high_ignored) else $error("narrow high base write taken");

    property p_enable_gates;
        @(posedge ref_clk) disable iff (reset) !low_en |=> !bar_enabled;
    endproperty
    a_enable_gates: assert property (p_enable_gates) else $error("bar enabled while enable clear");

    property p_tbase_sticky;
        @(posedge ref_clk) (hot_reset && !reset) |=> $stable(tbase_high);
    endproperty
    a_tbase_sticky: assert property (p_tbase_sticky) else $error("upper base lost on hot reset");

    property p_wide_flag;
        @(posedge ref_clk) disable iff (reset) wide_mode |=> bar_wide;
    endproperty
    a_wide_flag: assert property (p_wide_flag) else $error("wide flag not set");

    property p_translated_high;
        @(posedge ref_clk) disable iff (reset) wide_mode |=> (translated_base_addr[63:32] == $past(tbase_high));
    endproperty
    a_translated_high: assert property (p_translated_high) else $error("translated high not from upper base");

    property p_size_hot;
        @(posedge ref_clk) (hot_reset && !reset) |=> (low_size == `NBS_SIZE_RST);
    endproperty
    a_size_hot: assert property (p_size_hot) else $error("size not one after hot reset");

    property p_base_high_narrow_read;
        @(posedge ref_clk) disable iff (reset) (reg_rd && hit_base_high && !wide_mode) |=> (reg_rdata == 32'h0);
    endproperty
    a_base_high_narrow_read: assert property (p_base_high_narrow_read) else $error("narrow high base nonzero");

    property p_tbase_nibble;
        @(posedge ref_clk) disable iff (reset) (reg_rd && hit_tbase_high && !wide_mode) |=> (reg_rdata[3:0] == 4'h0);
    endproperty
    a_tbase_nibble: assert property (p_tbase_nibble) else $error("narrow upper base low bits nonzero");

    property p_io_flag;
        @(posedge ref_clk) disable iff (reset) low_space |=> bar_is_io;
    endproperty
    a_io_flag: assert property (p_io_flag) else $error("io flag not set");
endmodule

// file: src/nbs_map.svh
// Register map, field positions and reset values for the BAR setup block
`ifndef NBS_MAP_SVH
`define NBS_MAP_SVH
`define NBS_OFF_SETUP_LOW 12'h07c
`define NBS_OFF_SETUP_HIGH 12'h084
`define NBS_OFF_TBASE_HIGH 12'h088
`define NBS_OFF_BASE_LOW 12'h090
`define NBS_OFF_BASE_HIGH 12'h094
`define NBS_OFF_STATUS 12'h098
`define NBS_SPACE_BIT 0
`define NBS_TYPE_LSB 1
`define NBS_TYPE_MSB 2
`define NBS_PREF_BIT 3
`define NBS_SIZE_LSB 4
`define NBS_SIZE_MSB 9
`define NBS_EN_BIT 31
`define NBS_SIZE_RST 6'h01
`define NBS_SIZE_MIN 7'h04
`define NBS_SIZE_32 7'h20
`define NBS_TYPE_ADDR32 2'h0
`define NBS_TYPE_ADDR64 2'h2
`define NBS_SPACE_MEM 1'h0
`define NBS_SPACE_IO 1'h1
`define NBS_BASE_SHIFT 4
`endif

// file: src/nbs_pkg.sv
// Types shared by the BAR setup block
package nbs_pkg;
    typedef logic [11:0] nbs_addr_t;
    typedef logic [31:0] nbs_word_t;
    typedef enum logic [2:0] {
        NBS_RST_NONE = 3'h1,
        NBS_RST_HOT = 3'h2,
        NBS_RST_FULL = 3'h4
    } nbs_rst_kind_t;
endpackage

// file: src/nbs_base_mask.sv
// Writable-bit mask of a 60-bit BAR base field from size and decode mode
`timescale 1ns/1ps
`include "nbs_map.svh"
module nbs_base_mask (
    // Setup fields
    input wire logic [5:0] size,
    input wire logic wide_decode,
    // Mask of writable base bits, bit i is address bit i+4
    output logic [59:0] mask
);
    logic [6:0] eff_size;

    // Narrow decode clips size at 32
    assign eff_size = (!wide_decode && {1'b0, size} > `NBS_SIZE_32) ? `NBS_SIZE_32 : {1'b0, size};

    always_comb begin
        mask = '0;
        for (int i = 0; i < 60; i++) begin
            if (size == 6'h00) begin
                mask[i] = 1'b1;
            end else if (eff_size < `NBS_SIZE_MIN) begin
                mask[i] = 1'b0;
            end else begin
                mask[i] = (7'(i + `NBS_BASE_SHIFT) >= eff_size);
            end
        end
        if (!wide_decode) begin
            mask[59:28] = '0;
        end
    end
endmodule

// file: verif/ntb_bar_size_setup_bench.sv
// Self-checking bench for the BAR setup block
`timescale 1ns/1ps
`include "nbs_map.svh"
module ntb_bar_size_setup_bench;
    import nbs_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic hot_reset = 1'b0;
    nbs_addr_t reg_addr = 12'h000;
    nbs_word_t reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    nbs_word_t reg_rdata;
    logic bar_enabled, bar_is_io, bar_wide;
    logic [63:0] bar_base_addr, translated_base_addr;
    int n_errors = 0;
    int tests_run = 0;
    logic [31:0] seed = 32'h36;
    nbs_word_t w, d;
    logic [5:0] sizes [10] = '{6'h00, 6'h01, 6'h03, 6'h04, 6'h05, 6'h07, 6'h1f, 6'h20, 6'h21, 6'h3f};

    nbs_setup dut (.ref_clk(ref_clk), .reset(reset), .hot_reset(hot_reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .bar_enabled(bar_enabled), .bar_is_io(bar_is_io), .bar_wide(bar_wide),
        .bar_base_addr(bar_base_addr), .translated_base_addr(translated_base_addr));

    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    function logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Readback of setup: reserved bits zero, type forced to zero for I/O
    function nbs_word_t exp_setup(input nbs_word_t v);
        nbs_word_t e;
        e = v & 32'h8000_03ff;
        if (v[0]) begin
            e[2:1] = 2'h0;
        end
        return e;
    endfunction

    // Writable base bits, bit i stands for address bit i+4
    function logic [59:0] exp_mask(input logic [5:0] s, input logic wide);
        logic [59:0] m;
        int eff;
        eff = (!wide && s > 6'h20) ? 32 : int'(s);
        for (int i = 0; i < 60; i++) begin
            m[i] = (s == 6'h00) || (s >= 6'h04 && i + 4 >= eff);
        end
        return m;
    endfunction

    function nbs_word_t exp_low(input nbs_word_t v, input nbs_word_t b);
        nbs_word_t s;
        logic [59:0] m;
        s = exp_setup(v);
        m = exp_mask(s[9:4], !s[0] && s[2:1] == 2'h2);
        return s[31] ? {b[31:4] & m[27:0], 3'h0, s[0]} : 32'h0;
    endfunction

    task automatic check(input nbs_word_t got, input nbs_word_t exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input nbs_addr_t a, input nbs_word_t v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input nbs_addr_t a, input nbs_word_t exp, input string what);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp, what);
    endtask

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Run limit
    initial begin
        #(100 * 20000);
        n_errors++;
        $display("[FAIL] %0t run limit reached", $time);
        summarize();
    end

    initial begin
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        wr(`NBS_OFF_SETUP_LOW, 32'h8000_0200);
        rd(`NBS_OFF_SETUP_LOW, 32'h8000_0200, "setup readback");
        check({31'h0, bar_enabled}, 32'h1, "enabled flag");
        wr(`NBS_OFF_TBASE_HIGH, 32'hffff_ffff);
        rd(`NBS_OFF_TBASE_HIGH, 32'hffff_fff0, "narrow upper base");
        wr(12'h0a0, 32'h1234_5678);
        rd(12'h0a0, 32'h0, "unmapped read");
        @(posedge ref_clk);
        hot_reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        hot_reset <= 1'b0;
        rd(`NBS_OFF_SETUP_LOW, 32'h8000_0010, "hot reset keeps enable");
        rd(`NBS_OFF_TBASE_HIGH, 32'hffff_fff0, "hot reset keeps upper base");
        $display("test done: basic and hot reset");
        foreach (sizes[k]) begin
            w = 32'h8000_0000 | {22'h0, sizes[k], 4'h0};
            wr(`NBS_OFF_SETUP_LOW, w);
            wr(`NBS_OFF_BASE_LOW, 32'hffff_fff0);
            rd(`NBS_OFF_BASE_LOW, exp_low(w, 32'hffff_fff0), "base mask");
        end
        wr(`NBS_OFF_SETUP_LOW, 32'h0000_0000);
        wr(`NBS_OFF_BASE_LOW, 32'hffff_fff0);
        rd(`NBS_OFF_BASE_LOW, 32'h0, "disabled base");
        $display("test done: size sweep");
        wr(`NBS_OFF_SETUP_LOW, 32'h8000_0045);
        rd(`NBS_OFF_SETUP_LOW, 32'h8000_0041, "io type forced");
        check({30'h0, bar_is_io, bar_wide}, 32'h2, "io decode");
        wr(`NBS_OFF_SETUP_HIGH, 32'hffff_ffff);
        rd(`NBS_OFF_SETUP_HIGH, exp_setup(32'hffff_ffff), "upper setup narrow");
        rd(`NBS_OFF_STATUS, 32'h3, "status io");
        wr(`NBS_OFF_BASE_HIGH, 32'hffff_ffff);
        rd(`NBS_OFF_BASE_HIGH, 32'h0, "narrow base high");
        check(translated_base_addr[63:32], 32'h0, "narrow translated high");
        $display("test done: io space");
        wr(`NBS_OFF_SETUP_LOW, 32'h8000_0284);
        wr(`NBS_OFF_SETUP_HIGH, 32'hffff_ffff);
        rd(`NBS_OFF_SETUP_HIGH, 32'h0, "upper setup in wide");
        wr(`NBS_OFF_TBASE_HIGH, 32'h1234_5678);
        rd(`NBS_OFF_TBASE_HIGH, 32'h1234_5678, "wide upper base");
        wr(`NBS_OFF_BASE_HIGH, 32'hffff_ffff);
        rd(`NBS_OFF_BASE_HIGH, 32'hffff_ff00, "wide base high");
        wr(`NBS_OFF_BASE_LOW, 32'hffff_fff0);
        rd(`NBS_OFF_BASE_LOW, 32'h0, "wide base low");
        check(translated_base_addr[63:32], 32'h1234_5678, "translated high");
        check(bar_base_addr[63:32], 32'hffff_ff00, "base address high");
        check({31'h0, bar_wide}, 32'h1, "wide flag");
        $display("test done: wide mode");
        repeat (24) begin
            seed = lfsr_next(seed);
            w = seed & 32'hc000_07fd;
            seed = lfsr_next(seed);
            d = seed;
            wr(`NBS_OFF_SETUP_LOW, w);
            wr(`NBS_OFF_BASE_LOW, d);
            rd(`NBS_OFF_SETUP_LOW, exp_setup(w), "random setup");
            rd(`NBS_OFF_BASE_LOW, exp_low(w, d), "random base");
        end
        $display("test done: random");
        summarize();
    end
endmodule
